// *** hdl/das_dev.sv ***
// Device end: conversion sequencing, power states and the
// configuration port slave with its control register.
// Assumes link pins are asynchronous to clk and are synchronised here.
`timescale 1ns/1ns
module das_dev #(
  parameter int WAKE_CYCLES = das_pkg::WAKE_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Link to host
  das_link_if.dev          link,
  // Sampled inputs of all channels
  input  das_pkg::das_res_t chanSample,
  // Control register outputs
  output logic             bandgapEn,
  output logic             refBufEn,
  output logic             lvdsTermEn,
  output logic             lvdsHalfBias,
  // Status
  output logic             ready,
  output logic             acquiring
);

  typedef enum logic [1:0] {
    PWR_WAKE  = 2'b00,
    PWR_READY = 2'b01,
    PWR_CONV  = 2'b10,
    PWR_DOWN  = 2'b11
  } das_pwr_t;

  typedef struct packed {
    logic [4:0]        syncA;
    logic [4:0]        syncB;
    logic [4:0]        prevB;
    das_pwr_t          st;
    logic [16:0]       wake;
    logic [6:0]        conv;
    logic [8:0]        acq;
    das_pkg::das_res_t hold;
    das_pkg::das_res_t res;
    logic              busy;
    logic              rdy;
    logic              acqg;
    logic [7:0]        ctl;
    logic [4:0]        bits;
    logic [23:0]       sh;
    logic              rdF;
    logic [7:0]        rd;
    logic              dio;
    logic              dioOe;
    logic              doOut;
    logic              doOe;
  } das_dev_state_t;

  localparam das_dev_state_t RST_STATE = '{
    st:      PWR_WAKE,
    ctl:     das_pkg::DEVCTL_RST,
    default: '0
  };

  // Sync vector bit positions
  localparam int S_CNV = 0;
  localparam int S_PD  = 1;
  localparam int S_SCK = 2;
  localparam int S_CS  = 3;
  localparam int S_DIO = 4;

  das_dev_state_t q;
  das_dev_state_t d;
  logic           cnvRise;
  logic           sckRise;
  logic           sckFall;
  logic           din;
  logic [14:0]    rdAddr;
  logic [14:0]    wrAddr;

  // Register readback of the configuration space
  function automatic logic [7:0] regRead(input das_dev_state_t s,
                                         input logic [14:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a == das_pkg::DEVCTL_ADDR) begin
      v = s.ctl;
    end else if (a == das_pkg::DEVSTAT_ADDR) begin
      v = {4'h0, s.acqg, s.busy, s.rdy, (s.st == PWR_DOWN)};
    end
    return v;
  endfunction : regRead

  assign cnvRise = q.syncB[S_CNV] & ~q.prevB[S_CNV];
  assign sckRise = q.syncB[S_SCK] & ~q.prevB[S_SCK];
  assign sckFall = ~q.syncB[S_SCK] & q.prevB[S_SCK];
  assign din     = q.syncB[S_DIO];
  assign rdAddr  = {q.sh[13:0], din};
  assign wrAddr  = q.sh[21:7];

  always_comb begin
    d = q;
    d.syncA = {link.configDataBidir, link.configCs_n, link.configClock,
               link.powerDownPin, link.convertStrobe};
    d.syncB = q.syncA;
    d.prevB = q.syncB;

    // Power and conversion sequencing
    unique case (q.st)
      PWR_WAKE: begin
        d.wake = q.wake + 17'h0_0001;
        if (q.wake == 17'(WAKE_CYCLES - 1)) begin
          d.st  = PWR_READY;
          d.acq = 9'(das_pkg::ACQ_CYC);
        end
      end
      PWR_READY: begin
        if (q.acq != 9'(das_pkg::ACQ_CYC)) begin
          d.acq = q.acq + 9'h001;
        end
        if (cnvRise) begin
          // All channels are captured on the same strobe
          d.st   = PWR_CONV;
          d.busy = 1'b1;
          d.conv = 7'h00;
          d.hold = chanSample;
        end
      end
      PWR_CONV: begin
        d.conv = q.conv + 7'h01;
        if (q.conv == 7'(das_pkg::CONV_CYC - 1 - das_pkg::LEAD_CYC)) begin
          d.res = q.hold;
        end
        if (q.conv == 7'(das_pkg::CONV_CYC - 1)) begin
          d.busy = 1'b0;
          d.st   = PWR_READY;
          d.acq  = 9'h000;
        end
      end
      PWR_DOWN: begin
        if (!q.syncB[S_PD]) begin
          d.st   = PWR_WAKE;
          d.wake = 17'h0_0000;
        end
      end
    endcase

    // Power-down pin aborts any conversion
    if (q.syncB[S_PD]) begin
      d.st   = PWR_DOWN;
      d.busy = 1'b0;
    end
    d.rdy  = (d.st == PWR_READY);
    d.acqg = (d.st == PWR_READY) && (d.acq != 9'(das_pkg::ACQ_CYC));

    // Configuration port slave
    if (q.syncB[S_CS]) begin
      d.bits  = 5'h00;
      d.rdF   = 1'b0;
      d.dioOe = 1'b0;
      d.doOe  = 1'b0;
    end else begin
      if (q.ctl[das_pkg::CTL_WIRE4]) begin
        d.doOe = 1'b1;
      end
      if (sckRise && q.bits < das_pkg::FRAME_BITS) begin
        d.bits = q.bits + 5'h01;
        if (q.bits < das_pkg::HDR_BITS || !q.rdF) begin
          d.sh = {q.sh[22:0], din};
        end
        if (q.bits == das_pkg::HDR_BITS - 5'h01) begin
          d.rdF = q.sh[14];
          d.rd  = regRead(q, rdAddr);
          if (q.sh[14] && !q.ctl[das_pkg::CTL_WIRE4]) begin
            d.dioOe = 1'b1;
          end
        end
        if (q.bits == das_pkg::FRAME_BITS - 5'h01 && !q.rdF &&
            wrAddr == das_pkg::DEVCTL_ADDR) begin
          d.ctl = {q.sh[6:0], din};
        end
      end
      if (sckFall && q.rdF && q.bits >= das_pkg::HDR_BITS &&
          q.bits < das_pkg::FRAME_BITS) begin
        // Same bit goes to both lines; the enables pick the wire
        d.dio   = q.rd[7];
        d.doOut = q.rd[7];
        d.rd    = {q.rd[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign link.busy            = q.busy;
  assign link.resultData      = q.res;
  assign link.bidirDevOut     = q.dio;
  assign link.bidirDevOe      = q.dioOe;
  assign link.configDataOut   = q.doOut;
  assign link.configDataOutOe = q.doOe;
  assign bandgapEn    = q.ctl[das_pkg::CTL_BANDGAP];
  assign refBufEn     = q.ctl[das_pkg::CTL_BUFFERED_REFERENCE_PIN];
  assign lvdsTermEn   = q.ctl[das_pkg::CTL_LVDSTERM];
  assign lvdsHalfBias = q.ctl[das_pkg::CTL_HALFBIAS];
  assign ready        = q.rdy;
  assign acquiring    = q.acqg;

endmodule : das_dev

// *** hdl/das_host.sv ***
// Host end: paces convert strobes, collects results on busy fall,
// drives power-down and masters the configuration port.
// Assumes a software command port on the same clock as the host.
//
// The register offsets and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module das_host (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Link to device
  das_link_if.host         link,
  // Command port
  input  wire logic [7:0]  cmdAddr,
  input  wire logic [31:0] cmdWdata,
  input  wire logic        cmdWrite,
  input  wire logic        cmdRead,
  output logic [31:0]      cmdRdata
);

  typedef enum logic [2:0] {
    SP_IDLE = 3'b000,
    SP_LEAD = 3'b001,
    SP_LOW  = 3'b010,
    SP_HIGH = 3'b011,
    SP_TAIL = 3'b100,
    SP_GAP  = 3'b101
  } das_spi_t;

  typedef struct packed {
    logic [2:0]        syncA;
    logic [2:0]        syncB;
    logic              prevBusy;
    logic              pend;
    logic [3:0]        ctl;
    logic              pdPin;
    logic [2:0]        pdCnt;
    logic              convert_strobe;
    logic [2:0]        cnvCnt;
    logic [8:0]        cyc;
    logic [1:0]        gap;
    das_pkg::das_res_t res;
    das_pkg::das_res_t resA;
    das_pkg::das_res_t resB;
    logic              resNew;
    das_spi_t          sst;
    logic [3:0]        tick;
    logic [4:0]        bits;
    logic [23:0]       sh;
    logic              rdMode;
    logic              wire4;
    logic [7:0]        rdb;
    logic [7:0]        cfgRd;
    logic              sck;
    logic              cs_n;
    logic              dOut;
    logic              dOe;
    logic [31:0]       rdata;
  } das_host_state_t;

  localparam das_host_state_t RST_STATE = '{
    sst:     SP_IDLE,
    cs_n:    1'b1,
    cyc:     9'(das_pkg::CYC_CYC - 1),
    gap:     2'(das_pkg::SCKCNV_CYC),
    default: '0
  };

  das_host_state_t q;
  das_host_state_t d;
  logic            busyFall;
  logic            sampled;
  logic [23:0]     frame;

  function automatic logic [31:0] hostRead(input das_host_state_t s,
                                           input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == das_pkg::H_CTRL) begin
      v = {28'h000_0000, s.ctl};
    end else if (a == das_pkg::H_STAT) begin
      v = {27'h000_0000, s.resNew, (s.sst != SP_IDLE), s.syncB[0],
           s.pend, s.pdPin};
    end else if (a == das_pkg::H_CFGRD) begin
      v = {24'h00_0000, s.cfgRd};
    end else if (a[7:5] == das_pkg::H_RES0[7:5] && a[1:0] == 2'b00) begin
      v = {12'h000, s.res[a[4:2]]};
    end
    return v;
  endfunction : hostRead

  assign busyFall = q.prevBusy & ~q.syncB[0];
  assign sampled  = q.wire4 ? q.syncB[2] : q.syncB[1];

  // Control-register writes go out with band-gap off under HC_EXTREF or HC_EXTBUF, and buffer off under HC_EXTBUF
  always_comb begin
    frame = {cmdWdata[das_pkg::CMD_RD], cmdWdata[14:0], cmdWdata[23:16]};
    if (!cmdWdata[das_pkg::CMD_RD] && cmdWdata[14:0] == das_pkg::DEVCTL_ADDR)
    begin
      if (q.ctl[das_pkg::HC_EXTREF] || q.ctl[das_pkg::HC_EXTBUF]) begin
        frame[das_pkg::CTL_BANDGAP] = 1'b0;
      end
      if (q.ctl[das_pkg::HC_EXTBUF]) begin
        frame[das_pkg::CTL_BUFFERED_REFERENCE_PIN] = 1'b0;
      end
    end
  end

  always_comb begin
    d = q;
    d.syncA = {link.configDataOutLevel, link.configDataBidir, link.busy};
    d.syncB = q.syncA;
    d.resA  = link.resultData;
    d.resB  = q.resA;
    d.prevBusy = q.syncB[0];
    d.rdata = cmdRead ? hostRead(q, cmdAddr) : 32'h0000_0000;
    if (q.cyc != 9'(das_pkg::CYC_CYC - 1)) begin
      d.cyc = q.cyc + 9'h001;
    end
    if (q.gap != 2'(das_pkg::SCKCNV_CYC)) begin
      d.gap = q.gap + 2'h1;
    end

    // Power-down pin keeps each level for its least time
    if (q.pdCnt != 3'(das_pkg::PD_CYC - 1)) begin
      d.pdCnt = q.pdCnt + 3'h1;
    end else if (q.pdPin != q.ctl[das_pkg::HC_PD]) begin
      d.pdPin = q.ctl[das_pkg::HC_PD];
      d.pdCnt = 3'h0;
    end

    // Convert strobe pacing
    if (q.convert_strobe) begin
      d.cnvCnt = q.cnvCnt + 3'h1;
      if (q.cnvCnt == 3'(das_pkg::CNVH_CYC - 1)) begin
        d.convert_strobe = 1'b0;
      end
    end else if (q.pend && !q.pdPin && !q.syncB[0] &&
                 q.cyc == 9'(das_pkg::CYC_CYC - 1) &&
                 q.gap == 2'(das_pkg::SCKCNV_CYC)) begin
      d.convert_strobe    = 1'b1;
      d.cnvCnt = 3'h0;
      d.cyc    = 9'h000;
      d.pend   = 1'b0;
    end

    // Command writes; the start of a conversion request wins
    if (cmdWrite) begin
      if (cmdAddr == das_pkg::H_CTRL) begin
        d.ctl[3:1] = cmdWdata[3:1];
        if (cmdWdata[das_pkg::HC_GO]) begin
          d.pend = 1'b1;
        end
      end else if (cmdAddr == das_pkg::H_STAT && cmdWdata[das_pkg::HS_NEW])
      begin
        d.resNew = 1'b0;
      end else if (cmdAddr == das_pkg::H_CFGCMD && q.sst == SP_IDLE) begin
        d.sh     = frame;
        d.rdMode = cmdWdata[das_pkg::CMD_RD];
        d.wire4  = cmdWdata[das_pkg::CMD_WIRE4];
        d.sst    = SP_LEAD;
        d.tick   = 4'h0;
        d.bits   = 5'h00;
        d.cs_n   = 1'b0;
      end
    end

    // Power-down drops pending convert requests; one made after the pin falls can still fire during wake
    if (q.pdPin) begin
      d.pend = 1'b0;
    end

    // Results settle before busy falls and have passed both stages
    if (busyFall) begin
      d.res    = q.resB;
      d.resNew = 1'b1;
      d.gap    = 2'h0;
    end

    // Configuration port master
    if (q.sst != SP_IDLE) begin
      d.tick = q.tick + 4'h1;
    end
    unique case (q.sst)
      SP_IDLE: ;
      SP_LEAD: begin
        if (q.tick == 4'(das_pkg::CS_CYC - 1)) begin
          d.sst  = SP_LOW;
          d.tick = 4'h0;
          d.dOut = q.sh[23];
          d.dOe  = 1'b1;
        end
      end
      SP_LOW: begin
        if (q.tick == 4'(das_pkg::SCK_HALF_CYC - 1)) begin
          d.sst  = SP_HIGH;
          d.tick = 4'h0;
          d.sck  = 1'b1;
          d.bits = q.bits + 5'h01;
          if (q.rdMode && q.bits >= das_pkg::HDR_BITS) begin
            d.rdb = {q.rdb[6:0], sampled};
          end
        end
      end
      SP_HIGH: begin
        // Hold the last address bit one clock past the 16th rise,
        // then free the line well before the device takes it over
        if (q.rdMode && q.bits == das_pkg::HDR_BITS && q.tick == 4'h0) begin
          d.dOe = 1'b0;
        end
        if (q.tick == 4'(das_pkg::SCK_HALF_CYC - 1)) begin
          d.tick = 4'h0;
          d.sck  = 1'b0;
          if (q.bits == das_pkg::FRAME_BITS) begin
            d.sst = SP_TAIL;
            d.dOe = 1'b0;
          end else begin
            d.sst  = SP_LOW;
            d.sh   = {q.sh[22:0], 1'b0};
            d.dOut = q.sh[22];
          end
        end
      end
      SP_TAIL: begin
        if (q.tick == 4'(das_pkg::CS_CYC - 1)) begin
          d.sst  = SP_GAP;
          d.tick = 4'h0;
          d.cs_n = 1'b1;
          if (q.rdMode) begin
            d.cfgRd = q.rdb;
          end
        end
      end
      SP_GAP: begin
        if (q.tick == 4'(das_pkg::CS_CYC - 1)) begin
          d.sst = SP_IDLE;
        end
      end
      default: begin
        d.sst  = SP_IDLE;
        d.cs_n = 1'b1;
        d.sck  = 1'b0;
        d.dOe  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_STATE;
    end else begin
      q <= d;
    end
  end

  assign link.convertStrobe = q.convert_strobe;
  assign link.powerDownPin  = q.pdPin;
  assign link.configClock   = q.sck;
  assign link.configCs_n    = q.cs_n;
  assign link.bidirHostOut  = q.dOut;
  assign link.bidirHostOe   = q.dOe;
  assign cmdRdata           = q.rdata;

endmodule : das_host

// *** pkg/das_link_if.sv ***
// Link between the host end and the device end of the sequencer.
// Both ends run on their own 100 MHz clock; the link is asynchronous.
`timescale 1ns/1ns
interface das_link_if;
  logic              convertStrobe;
  logic              powerDownPin;
  logic              busy;
  das_pkg::das_res_t resultData;
  logic              configClock;
  logic              configCs_n;
  logic              bidirHostOut;
  logic              bidirHostOe;
  logic              bidirDevOut;
  logic              bidirDevOe;
  logic              configDataOut;
  logic              configDataOutOe;
  logic              configDataBidir;
  logic              configDataOutLevel;

  // Undriven lines float high through a weak pull-up
  assign configDataBidir = bidirHostOe ? bidirHostOut :
                           (bidirDevOe ? bidirDevOut : 1'b1);
  assign configDataOutLevel = configDataOutOe ? configDataOut : 1'b1;

  modport dev (
    input  convertStrobe, powerDownPin, configClock, configCs_n,
    input  configDataBidir,
    output busy, resultData, bidirDevOut, bidirDevOe,
    output configDataOut, configDataOutOe
  );
  modport host (
    output convertStrobe, powerDownPin, configClock, configCs_n,
    output bidirHostOut, bidirHostOe,
    input  busy, resultData, configDataBidir, configDataOutLevel
  );
endinterface : das_link_if

// *** pkg/das_pkg.sv ***
// Shared constants for the acquisition sequencer: timing counts,
// configuration frame layout, device and host register maps.
// Assumes a 100 MHz system clock at both ends.
package das_pkg;
  localparam int CLK_NS       = 10;
  localparam int CHANNELS     = 8;
  localparam int RES_BITS     = 20;
  typedef logic [CHANNELS-1:0][RES_BITS-1:0] das_res_t;

  // Conversion timing
  localparam int CYC_NS       = 4000;
  localparam int CYC_CYC      = (CYC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNVH_NS      = 40;
  localparam int CNVH_CYC     = (CNVH_NS + CLK_NS - 1) / CLK_NS;
  localparam int CONV_MIN_NS  = 605;
  localparam int CONV_TYP_NS  = 665;
  localparam int CONV_MAX_NS  = 725;
  localparam int CONV_CYC     = CONV_TYP_NS / CLK_NS;
  localparam int LEAD_NS      = 2;
  localparam int LEAD_CYC     = (LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACQ_NS       = 3465;
  localparam int ACQ_CYC      = (ACQ_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCKCNV_NS    = 20;
  localparam int SCKCNV_CYC   = (SCKCNV_NS + CLK_NS - 1) / CLK_NS;
  localparam int PD_MIN_NS    = 40;
  localparam int PD_CYC       = (PD_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_MS      = 1;
  localparam int WAKE_CYC     = WAKE_MS * 1000000 / CLK_NS;

  // Configuration port timing and frame
  localparam int SCK_HALF_NS  = 60;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int CS_NS        = 15;
  localparam int CS_CYC       = (CS_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] HDR_BITS   = 5'h10;
  localparam logic [4:0] FRAME_BITS = 5'h18;

  // Device registers and control fields
  localparam logic [14:0] DEVCTL_ADDR  = 15'h0000;
  localparam logic [14:0] DEVSTAT_ADDR = 15'h0001;
  localparam int CTL_BANDGAP  = 0;
  localparam int CTL_BUFFERED_REFERENCE_PIN   = 1;
  localparam int CTL_LVDSTERM = 2;
  localparam int CTL_HALFBIAS = 3;
  localparam int CTL_WIRE4    = 4;
  localparam logic [7:0] DEVCTL_RST = 8'h17;

  // Host command registers
  localparam logic [7:0] H_CTRL   = 8'h00;
  localparam logic [7:0] H_STAT   = 8'h04;
  localparam logic [7:0] H_CFGCMD = 8'h08;
  localparam logic [7:0] H_CFGRD  = 8'h0C;
  localparam logic [7:0] H_RES0   = 8'h20;
  localparam int HC_GO      = 0;
  localparam int HC_PD      = 1;
  localparam int HC_EXTREF  = 2;
  localparam int HC_EXTBUF  = 3;
  localparam int HS_NEW     = 4;
  localparam int CMD_RD     = 15;
  localparam int CMD_WIRE4  = 24;
endpackage : das_pkg

// *** testbench/das_conversion_sequencing_tb_top.sv ***
// Bench: host and device ends joined over the link, driven through
// the host command port. Assumes both ends share one clock.
`timescale 1ns/1ns
module das_conversion_sequencing_tb_top;
  localparam int WAKE = 50;
  logic              clk;
  logic              rst_n;
  logic [7:0]        cmdAddr;
  logic [31:0]       cmdWdata;
  logic              cmdWrite;
  logic              cmdRead;
  logic [31:0]       cmdRdata;
  das_pkg::das_res_t chanSample;
  logic              bandgapEn;
  logic              refBufEn;
  logic              lvdsTermEn;
  logic              lvdsHalfBias;
  logic              ready;
  logic              acquiring;
  int                mismatches = 0;
  int                check_count = 0;
  int                cycles = 0;

  das_link_if link ();
  das_dev #(.WAKE_CYCLES(WAKE)) i_das_dev (
    .clk(clk), .rst_n(rst_n), .link(link), .chanSample(chanSample),
    .bandgapEn(bandgapEn), .refBufEn(refBufEn), .lvdsTermEn(lvdsTermEn),
    .lvdsHalfBias(lvdsHalfBias), .ready(ready), .acquiring(acquiring));
  das_host i_das_host (
    .clk(clk), .rst_n(rst_n), .link(link), .cmdAddr(cmdAddr),
    .cmdWdata(cmdWdata), .cmdWrite(cmdWrite), .cmdRead(cmdRead),
    .cmdRdata(cmdRdata));
  das_link_assertions i_das_link_assertions (
    .clk(clk), .rst_n(rst_n), .convertStrobe(link.convertStrobe),
    .powerDownPin(link.powerDownPin), .busy(link.busy),
    .resultData(link.resultData), .configClock(link.configClock),
    .configCs_n(link.configCs_n), .bidirHostOut(link.bidirHostOut),
    .bidirHostOe(link.bidirHostOe), .bidirDevOut(link.bidirDevOut),
    .bidirDevOe(link.bidirDevOe), .configDataOut(link.configDataOut),
    .configDataOutOe(link.configDataOutOe));

  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  // Hang guard, well above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(logic [7:0] a, logic [31:0] d);
    cmdAddr  <= a;
    cmdWdata <= d;
    cmdWrite <= 1'b1;
    @(posedge clk);
    cmdWrite <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(logic [7:0] a, output logic [31:0] v);
    cmdAddr <= a;
    cmdRead <= 1'b1;
    @(posedge clk);
    cmdRead <= 1'b0;
    #1;
    v = cmdRdata;
    @(posedge clk);
  endtask : rd

  // Runs one frame; a second command mid-frame must be dropped
  task automatic cfg(logic [31:0] cmd);
    logic [31:0] s;
    int          n;
    wr(das_pkg::H_CFGCMD, cmd);
    wr(das_pkg::H_CFGCMD, cmd ^ 32'h00FF_0000);
    n = 0;
    s = '1;
    while (s[3] !== 1'b0 && n < 300) begin
      rd(das_pkg::H_STAT, s);
      n++;
    end
    chk("frame end", 32'(s[3]), 0);
  endtask : cfg

  function automatic logic [7:0] expCtl(logic [3:0] d, logic w,
                                        logic io, logic bf);
    return {3'b000, w, d[3], d[2], d[1] & !bf, d[0] & !io & !bf};
  endfunction : expCtl

  initial begin
    logic [31:0] v;
    logic [7:0]  e;
    logic [3:0]  d;
    logic        w;
    logic        io;
    logic        bf;
    int          n;
    void'($urandom(13));
    rst_n      = 1'b0;
    cmdAddr    = 8'h00;
    cmdWdata   = 32'h0000_0000;
    cmdWrite   = 1'b0;
    cmdRead    = 1'b0;
    chanSample = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tick();
    chk("ctl reset", 32'({bandgapEn, refBufEn, lvdsTermEn, lvdsHalfBias}),
        32'h0000_000E);
    n = 1;
    while (ready !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    chk("wake", 32'(n >= WAKE && n <= WAKE + 4), 1);
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 8; c++) begin
        chanSample[c] <= 20'($urandom);
      end
      wr(das_pkg::H_CTRL, 32'h0000_0001);
      n = 0;
      while (link.busy !== 1'b1 && n < 20) begin
        tick();
        n++;
      end
      n = 0;
      while (link.busy === 1'b1 && n < 100) begin
        tick();
        n++;
      end
      chk("busy length", 32'(n), 32'(das_pkg::CONV_CYC));
      n = 0;
      while (acquiring === 1'b1 && n < 500) begin
        tick();
        n++;
      end
      chk("acquire", 32'(n), 32'(das_pkg::ACQ_CYC));
      rd(das_pkg::H_STAT, v);
      chk("new flag", 32'(v[das_pkg::HS_NEW]), 1);
      for (int c = 0; c < 8; c++) begin
        rd(das_pkg::H_RES0 + 8'(4 * c), v);
        chk("result", v, 32'(chanSample[c]));
      end
      wr(das_pkg::H_STAT, 32'h0000_0010);
      rd(das_pkg::H_STAT, v);
      chk("new clear", 32'(v[das_pkg::HS_NEW]), 0);
    end
    for (int k = 0; k < 6; k++) begin
      d  = 4'($urandom);
      io = 1'($urandom);
      bf = 1'($urandom);
      w  = k[0];
      e  = expCtl(d, w, io, bf);
      wr(das_pkg::H_CTRL, {28'h0, bf, io, 2'b00});
      wr(8'h10, 32'h0000_0001);
      cfg({7'h0, w, 3'b000, w, d, 1'b0, das_pkg::DEVCTL_ADDR});
      cfg({7'h0, w, 8'hFF, 16'h0002});
      chk("reference", 32'({bandgapEn, refBufEn}), 32'({e[0], e[1]}));
      chk("lvds", 32'({lvdsTermEn, lvdsHalfBias}), 32'({e[2], e[3]}));
      cfg({7'h0, w, 8'h00, 1'b1, das_pkg::DEVCTL_ADDR});
      rd(das_pkg::H_CFGRD, v);
      chk("readback", 32'(v[7:0]), 32'(e));
    end
    cfg({7'h0, w, 8'h00, 1'b1, das_pkg::DEVSTAT_ADDR});
    rd(das_pkg::H_CFGRD, v);
    chk("status", 32'(v[7:0]), 32'h0000_0002);
    wr(das_pkg::H_CTRL, 32'h0000_0002);
    wr(das_pkg::H_CTRL, 32'h0000_0003);
    rd(das_pkg::H_STAT, v);
    chk("pd pin", 32'(v[0]), 1);
    chk("pd pending", 32'(v[1]), 0);
    n = 0;
    while (link.busy !== 1'b1 && n < 40) begin
      tick();
      n++;
    end
    chk("pd refuses", 32'({link.busy, ready}), 0);
    wr(das_pkg::H_CTRL, 32'h0000_0000);
    n = 0;
    while (ready !== 1'b1 && n < 200) begin
      tick();
      n++;
    end
    chk("rewake", 32'(n <= WAKE + 8), 1);
    repeat (500) @(posedge clk);
    conclude();
  end
endmodule : das_conversion_sequencing_tb_top

// *** testbench/das_link_assertions.sv ***
// Checker on the link joining the host end and the device end.
// Assumes both ends run on clk with the shared active-low reset.
`timescale 1ns/1ns
module das_link_assertions (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst_n,
  // Link signals
  input wire logic              convertStrobe,
  input wire logic              powerDownPin,
  input wire logic              busy,
  input wire das_pkg::das_res_t resultData,
  input wire logic              configClock,
  input wire logic              configCs_n,
  input wire logic              bidirHostOut,
  input wire logic              bidirHostOe,
  input wire logic              bidirDevOut,
  input wire logic              bidirDevOe,
  input wire logic              configDataOut,
  input wire logic              configDataOutOe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  int   strobeGap_q;
  int   busyLen_q;
  int   sckRises_q;
  logic strobeDly_q;
  logic sckDly_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobeGap_q <= 1000;
      busyLen_q   <= 0;
      sckRises_q  <= 0;
      strobeDly_q <= 1'b0;
      sckDly_q    <= 1'b0;
    end else begin
      strobeDly_q <= convertStrobe;
      sckDly_q    <= configClock;
      strobeGap_q <= (convertStrobe && !strobeDly_q) ? 1 : strobeGap_q + 1;
      busyLen_q   <= busy ? busyLen_q + 1 : 0;
      sckRises_q  <= configCs_n ? 0 :
                     sckRises_q + int'(configClock && !sckDly_q);
    end
  end

  // Busy answers a strobe within a few clocks
  sequence convStart;
    ##[2:4] $rose(busy);
  endsequence

  a_strobe_spacing: assert property (
    $rose(convertStrobe) |-> strobeGap_q >= das_pkg::CYC_CYC)
    else $error("convert strobes closer than the cycle time");
  a_busy_prompt: assert property (
    $rose(convertStrobe) && !powerDownPin |-> convStart)
    else $error("busy did not follow the convert strobe");
  a_busy_cause: assert property (
    $rose(busy) |-> $past(convertStrobe, 3) && !$past(convertStrobe, 5))
    else $error("busy rose without a recent strobe");
  a_busy_length: assert property (
    $fell(busy) && !powerDownPin |-> busyLen_q == das_pkg::CONV_CYC)
    else $error("conversion length wrong");
  a_result_settled: assert property (
    $changed(resultData) |-> busy)
    else $error("results changed outside a conversion");
  a_host_setup: assert property (
    $changed(bidirHostOut) && bidirHostOe |-> !configClock)
    else $error("host data changed while the clock was high");
  a_turnaround: assert property (
    $rose(bidirDevOe) |-> sckRises_q == 16 && !configCs_n)
    else $error("device drove the shared line at the wrong edge");
  a_no_clash: assert property (
    !(bidirHostOe && bidirDevOe))
    else $error("both ends drive the shared line");
  a_read_on_fall: assert property (
    ($changed(bidirDevOut) && bidirDevOe && $past(bidirDevOe)) ||
    ($changed(configDataOut) && configDataOutOe && $past(configDataOutOe))
    |-> !configClock)
    else $error("read data changed while the clock was high");
  a_cs_release: assert property (
    configCs_n [*5] |-> !bidirDevOe && !configDataOutOe)
    else $error("device output enabled with the frame deselected");
endmodule : das_link_assertions
